// File: verilog/ppe_pkg.sv
// constants for the port b/c pullup enable block
package ppe_pkg;
   localparam int ppe_addr_w = 16;
   localparam int ppe_port_w = 8;
   localparam logic [15:0] ppe_off_portb_pe = 16'h30f1;
   localparam logic [15:0] ppe_off_portc_pe = 16'h30f2;
   localparam logic [7:0] ppe_rst_pe = 8'h00;
   localparam logic [7:0] ppe_rd_unmapped = 8'h00;
   // pin direction encoding supplied by the rest of the port logic
   typedef enum logic [2:0] {
      ppe_dir_input = 3'b001,
      ppe_dir_output = 3'b010,
      ppe_dir_hiz = 3'b100
   } ppe_dir_t;
endpackage

// File: verilog/ppe_enreg.sv
// one 8-bit pullup enable register, written on a strobe decoded by its parent
`timescale 1ns/1ps
module ppe_enreg (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // write port
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   // stored value
   output logic [7:0] o_q
);
   import ppe_pkg::*;
   logic [7:0] q_reg;
   logic [7:0] q_next;
   assign q_next = i_wr ? i_wdata : q_reg;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         q_reg <= ppe_rst_pe;
      end else begin
         q_reg <= q_next;
      end
   end
   assign o_q = q_reg;
endmodule

// File: verilog/ppe_gate.sv
// per-pin gating of pullup enables by pin direction
`timescale 1ns/1ps
module ppe_gate (
   // enables and pin state
   input wire logic [7:0] i_en,
   input wire logic [7:0] i_is_input,
   // gated pullup controls
   output logic [7:0] o_pull
);
   // pullup only acts on input pins
   assign o_pull = i_en & i_is_input; // [RULE4]
endmodule

// File: verilog/ppe_top.sv
// port b and port c pullup enable registers and pullup controls
// Behaviour
// RULE1 - port b pullup enable register at 0x30f1, bit n for pin n
// RULE2 - each port b pin pullup driven independently by its own bit
// RULE3 - writing 1 enables a pullup, writing 0 disables it
// RULE4 - pullup stays off while pin is output or high impedance; pull output is registered and lags pin direction by one clock
// RULE5 - port c pullup enable register at 0x30f2, bit 7 for pin 7
// RULE6 - each port c bit controls its own pin, same encoding and gating
// RULE7 - reads return last written value; reset clears all enables
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module ppe_top (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // register port
   input wire logic [ppe_pkg::ppe_addr_w-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // pin direction state from the data and direction logic
   input wire logic [7:0] i_portb_is_input,
   input wire logic [7:0] i_portc_is_input,
   // pullup controls to the pads
   output logic [7:0] o_port_b_pin_pull,
   output logic [7:0] o_port_c_pin_pull
);
   import ppe_pkg::*;

   logic [7:0] portb_pe;
   logic [7:0] portc_pe;
   logic [7:0] portb_gated;
   logic [7:0] portc_gated;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] pullb_reg;
   logic [7:0] pullc_reg;

   // address match shared by write and read decode
   function automatic logic ppe_hit(input logic [ppe_addr_w-1:0] addr, input logic [15:0] off);
      return addr == off;
   endfunction

   // address decode
   wire sel_b = ppe_hit(i_addr, ppe_off_portb_pe); // [RULE1]
   wire sel_c = ppe_hit(i_addr, ppe_off_portc_pe); // [RULE5]
   wire wr_b = i_wr & sel_b;
   wire wr_c = i_wr & sel_c;

   // per-pin enables by name
   wire portb_pull_en_bit0 = portb_pe[0];
   wire portb_pull_en_bit1 = portb_pe[1];
   wire portb_pull_en_bit2 = portb_pe[2];
   wire portb_pull_en_bit3 = portb_pe[3];
   wire portb_pull_en_bit4 = portb_pe[4];
   wire portb_pull_en_bit5 = portb_pe[5];
   wire portb_pull_en_bit6 = portb_pe[6];
   wire portb_pull_en_bit7 = portb_pe[7];
   wire portc_pull_en_bit0 = portc_pe[0];
   wire portc_pull_en_bit1 = portc_pe[1];
   wire portc_pull_en_bit2 = portc_pe[2];
   wire portc_pull_en_bit3 = portc_pe[3];
   wire portc_pull_en_bit4 = portc_pe[4];
   wire portc_pull_en_bit5 = portc_pe[5];
   wire portc_pull_en_bit6 = portc_pe[6];
   wire portc_pull_en_bit7 = portc_pe[7];

   // enable storage, 1 enables and 0 disables
   ppe_enreg u_portb (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_wr(wr_b), // [RULE3]
      .i_wdata(i_wdata),
      .o_q(portb_pe)
   );
   ppe_enreg u_portc (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_wr(wr_c), // [RULE6]
      .i_wdata(i_wdata),
      .o_q(portc_pe)
   );

   // direction gating per pin
   ppe_gate u_gate_b (
      .i_en(portb_pe), // [RULE2]
      .i_is_input(i_portb_is_input),
      .o_pull(portb_gated)
   );
   ppe_gate u_gate_c (
      .i_en(portc_pe), // [RULE6]
      .i_is_input(i_portc_is_input),
      .o_pull(portc_gated)
   );

   // read mux, unmapped reads return zero
   assign rdata_next = !i_rd ? ppe_rd_unmapped :
                       sel_b ? portb_pe :
                       sel_c ? portc_pe : ppe_rd_unmapped; // [RULE7]

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata_reg <= ppe_rst_pe;
         pullb_reg <= ppe_rst_pe; // [RULE7]
         pullc_reg <= ppe_rst_pe;
      end else begin
         rdata_reg <= rdata_next;
         pullb_reg <= portb_gated; // [RULE2] [RULE4]
         pullc_reg <= portc_gated; // [RULE5]
      end
   end

   assign o_rdata = rdata_reg;
   assign o_port_b_pin_pull = pullb_reg;
   assign o_port_c_pin_pull = pullc_reg;

   // checks
   property p_wr_b_reads_back;
      @(posedge i_clk) disable iff (i_srst)
      (i_wr && sel_b) ##1 (i_rd && sel_b && !i_wr) |=> (o_rdata == $past(i_wdata, 2));
   endproperty
   a_wr_b_reads_back: assert property (p_wr_b_reads_back) else $error("port b readback"); // [RULE1]

   property p_wr_c_reads_back;
      @(posedge i_clk) disable iff (i_srst)
      (i_wr && sel_c) ##1 (i_rd && sel_c && !i_wr) |=> (o_rdata == $past(i_wdata, 2));
   endproperty
   a_wr_c_reads_back: assert property (p_wr_c_reads_back) else $error("port c readback"); // [RULE5]

   property p_pull_b_follows;
      @(posedge i_clk) disable iff (i_srst)
      (i_wr && sel_b) ##1 ($stable(i_portb_is_input) && !(i_wr && sel_b)) |=>
         (o_port_b_pin_pull == ($past(i_wdata, 2) & $past(i_portb_is_input)));
   endproperty
   a_pull_b_follows: assert property (p_pull_b_follows) else $error("port b pull"); // [RULE2]

   property p_pull_c7_follows;
      @(posedge i_clk) disable iff (i_srst)
      (i_wr && sel_c) ##1 ($stable(i_portc_is_input) && !(i_wr && sel_c)) |=>
         (o_port_c_pin_pull[7] == ($past(i_wdata[7], 2) & $past(i_portc_is_input[7])));
   endproperty
   a_pull_c7_follows: assert property (p_pull_c7_follows) else $error("port c pin 7 pull"); // [RULE5]

   property p_write_one_enables;
      @(posedge i_clk) disable iff (i_srst)
      (i_wr && sel_b && i_wdata[0]) |=> portb_pe[0];
   endproperty
   a_write_one_enables: assert property (p_write_one_enables) else $error("bit not set"); // [RULE3]

   property p_write_zero_disables;
      @(posedge i_clk) disable iff (i_srst)
      (i_wr && sel_c && !i_wdata[3]) |=> !portc_pe[3] ##1 !o_port_c_pin_pull[3];
   endproperty
   a_write_zero_disables: assert property (p_write_zero_disables) else $error("bit not clear"); // [RULE6]

   property p_output_no_pull;
      @(posedge i_clk) disable iff (i_srst)
      $past(i_portb_is_input) == 8'h00 |-> o_port_b_pin_pull == 8'h00;
   endproperty
   a_output_no_pull: assert property (p_output_no_pull) else $error("pull on output"); // [RULE4]

   property p_reset_clears;
      @(posedge i_clk)
      i_srst |=> (portb_pe == 8'h00 && portc_pe == 8'h00 && o_port_b_pin_pull == 8'h00);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset not cleared"); // [RULE7]

   property p_idle_read_zero;
      @(posedge i_clk) disable iff (i_srst)
      !i_rd |=> (o_rdata == 8'h00);
   endproperty
   a_idle_read_zero: assert property (p_idle_read_zero) else $error("rdata not zero"); // [RULE7]

   property p_stray_wr_kept;
      @(posedge i_clk) disable iff (i_srst)
      (i_wr && !sel_b && !sel_c) |=>
         ($stable(portb_pe) && $stable(portc_pe));
   endproperty
   a_stray_wr_kept: assert property (p_stray_wr_kept) else $error("stray write landed"); // [RULE1]

   property p_stray_rd_zero;
      @(posedge i_clk) disable iff (i_srst)
      (i_rd && !sel_b && !sel_c) |=>
         (o_rdata == 8'h00);
   endproperty
   a_stray_rd_zero: assert property (p_stray_rd_zero) else $error("unmapped read data"); // [RULE7]

   property p_read_b_value;
      @(posedge i_clk) disable iff (i_srst)
      (i_rd && sel_b) |=>
         (o_rdata == $past(portb_pe));
   endproperty
   a_read_b_value: assert property (p_read_b_value) else $error("port b read data"); // [RULE7]

   property p_read_c_value;
      @(posedge i_clk) disable iff (i_srst)
      (i_rd && sel_c) |=>
         (o_rdata == $past(portc_pe));
   endproperty
   a_read_c_value: assert property (p_read_c_value) else $error("port c read data"); // [RULE7]

   property p_wr_b_keeps_c;
      @(posedge i_clk) disable iff (i_srst)
      (i_wr && sel_b) |=>
         $stable(portc_pe);
   endproperty
   a_wr_b_keeps_c: assert property (p_wr_b_keeps_c) else $error("port b write hit port c"); // [RULE2]

   property p_pull_b_bit0;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_b_pin_pull[0] == $past(portb_pull_en_bit0 & i_portb_is_input[0]));
   endproperty
   a_pull_b_bit0: assert property (p_pull_b_bit0) else $error("port b pin 0 pull"); // [RULE2]

   property p_pull_b_bit1;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_b_pin_pull[1] == $past(portb_pull_en_bit1 & i_portb_is_input[1]));
   endproperty
   a_pull_b_bit1: assert property (p_pull_b_bit1) else $error("port b pin 1 pull"); // [RULE2]

   property p_pull_b_bit2;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_b_pin_pull[2] == $past(portb_pull_en_bit2 & i_portb_is_input[2]));
   endproperty
   a_pull_b_bit2: assert property (p_pull_b_bit2) else $error("port b pin 2 pull"); // [RULE2]

   property p_pull_b_bit3;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_b_pin_pull[3] == $past(portb_pull_en_bit3 & i_portb_is_input[3]));
   endproperty
   a_pull_b_bit3: assert property (p_pull_b_bit3) else $error("port b pin 3 pull"); // [RULE2]

   property p_pull_b_bit4;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_b_pin_pull[4] == $past(portb_pull_en_bit4 & i_portb_is_input[4]));
   endproperty
   a_pull_b_bit4: assert property (p_pull_b_bit4) else $error("port b pin 4 pull"); // [RULE2]

   property p_pull_b_bit5;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_b_pin_pull[5] == $past(portb_pull_en_bit5 & i_portb_is_input[5]));
   endproperty
   a_pull_b_bit5: assert property (p_pull_b_bit5) else $error("port b pin 5 pull"); // [RULE2]

   property p_pull_b_bit6;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_b_pin_pull[6] == $past(portb_pull_en_bit6 & i_portb_is_input[6]));
   endproperty
   a_pull_b_bit6: assert property (p_pull_b_bit6) else $error("port b pin 6 pull"); // [RULE2]

   property p_pull_b_bit7;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_b_pin_pull[7] == $past(portb_pull_en_bit7 & i_portb_is_input[7]));
   endproperty
   a_pull_b_bit7: assert property (p_pull_b_bit7) else $error("port b pin 7 pull"); // [RULE2]

   property p_pull_c_bit0;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_c_pin_pull[0] == $past(portc_pull_en_bit0 & i_portc_is_input[0]));
   endproperty
   a_pull_c_bit0: assert property (p_pull_c_bit0) else $error("port c pin 0 pull"); // [RULE6]

   property p_pull_c_bit1;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_c_pin_pull[1] == $past(portc_pull_en_bit1 & i_portc_is_input[1]));
   endproperty
   a_pull_c_bit1: assert property (p_pull_c_bit1) else $error("port c pin 1 pull"); // [RULE6]

   property p_pull_c_bit2;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_c_pin_pull[2] == $past(portc_pull_en_bit2 & i_portc_is_input[2]));
   endproperty
   a_pull_c_bit2: assert property (p_pull_c_bit2) else $error("port c pin 2 pull"); // [RULE6]

   property p_pull_c_bit3;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_c_pin_pull[3] == $past(portc_pull_en_bit3 & i_portc_is_input[3]));
   endproperty
   a_pull_c_bit3: assert property (p_pull_c_bit3) else $error("port c pin 3 pull"); // [RULE6]

   property p_pull_c_bit4;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_c_pin_pull[4] == $past(portc_pull_en_bit4 & i_portc_is_input[4]));
   endproperty
   a_pull_c_bit4: assert property (p_pull_c_bit4) else $error("port c pin 4 pull"); // [RULE6]

   property p_pull_c_bit5;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_c_pin_pull[5] == $past(portc_pull_en_bit5 & i_portc_is_input[5]));
   endproperty
   a_pull_c_bit5: assert property (p_pull_c_bit5) else $error("port c pin 5 pull"); // [RULE6]

   property p_pull_c_bit6;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_c_pin_pull[6] == $past(portc_pull_en_bit6 & i_portc_is_input[6]));
   endproperty
   a_pull_c_bit6: assert property (p_pull_c_bit6) else $error("port c pin 6 pull"); // [RULE6]

   property p_pull_c_bit7;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |->
         (o_port_c_pin_pull[7] == $past(portc_pull_en_bit7 & i_portc_is_input[7]));
   endproperty
   a_pull_c_bit7: assert property (p_pull_c_bit7) else $error("port c pin 7 pull"); // [RULE5]
endmodule

// File: verification/ppe_top_test.sv
// self-checking bench for the port b/c pullup enable block
`timescale 1ns/1ps
module ppe_top_test;
   import ppe_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [ppe_addr_w-1:0] i_addr = '0;
   logic [7:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] i_portb_is_input = '0;
   logic [7:0] i_portc_is_input = '0;
   logic [7:0] o_rdata;
   logic [7:0] o_port_b_pin_pull;
   logic [7:0] o_port_c_pin_pull;
   logic rd_d = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] bd;
   logic [7:0] cd;
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int seed = 83657;
   ppe_top uut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_portb_is_input(i_portb_is_input),
      .i_portc_is_input(i_portc_is_input), .o_port_b_pin_pull(o_port_b_pin_pull),
      .o_port_c_pin_pull(o_port_c_pin_pull));
   always #20 i_clk = ~i_clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one access; read notes its expected data
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      if (!w) begin
         exp_q.push_back(d);
      end
      @(posedge i_clk);
   endtask
   // release strobes, then look at pulls mid-cycle
   task automatic pulls(input logic [7:0] eb, input logic [7:0] ec);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk(o_port_b_pin_pull, eb);
      chk(o_port_c_pin_pull, ec);
      @(posedge i_clk);
   endtask
   // read watcher and timeout
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles >= 1000) begin
         err_count++;
         stop_test();
      end else begin
         if (rd_d) begin
            chk(o_rdata, exp_q.pop_front());
         end
         rd_d <= i_rd & !i_srst;
      end
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      acc(1'b0, ppe_off_portb_pe, ppe_rst_pe);
      acc(1'b0, ppe_off_portc_pe, ppe_rst_pe);
      i_portb_is_input <= 8'hff;
      i_portc_is_input <= 8'hff;
      pulls(8'h00, 8'h00);
      acc(1'b1, ppe_off_portb_pe, 8'hff);
      acc(1'b1, ppe_off_portc_pe, 8'h80);
      pulls(8'hff, 8'h80);
      i_portb_is_input <= 8'h00;
      i_portc_is_input <= 8'h00;
      pulls(8'h00, 8'h00);
      i_portb_is_input <= 8'hff;
      i_portc_is_input <= 8'hff;
      acc(1'b1, ppe_off_portb_pe, 8'h00);
      pulls(8'h00, 8'h80);
      i_portc_is_input <= 8'h7f;
      pulls(8'h00, 8'h00);
      for (int k = 0; k < 16; k++) begin
         bd = 8'($random(seed));
         cd = 8'($random(seed));
         i_portb_is_input <= 8'($random(seed));
         i_portc_is_input <= 8'($random(seed));
         acc(1'b1, ppe_off_portb_pe, bd);
         acc(1'b0, ppe_off_portb_pe, bd);
         acc(1'b1, ppe_off_portc_pe, cd);
         acc(1'b0, ppe_off_portc_pe, cd);
         acc(1'b1, 16'h30f0, ~bd);
         acc(1'b1, 16'h30f3, ~cd);
         acc(1'b0, 16'h30f3, ppe_rd_unmapped);
         pulls(bd & i_portb_is_input, cd & i_portc_is_input);
      end
      i_srst <= 1'b1;
      @(posedge i_clk);
      i_srst <= 1'b0;
      acc(1'b0, ppe_off_portb_pe, ppe_rst_pe);
      acc(1'b0, ppe_off_portc_pe, ppe_rst_pe);
      pulls(8'h00, 8'h00);
      stop_test();
   end
endmodule
